// [core/sms_sequencer.sv]
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module sms_sequencer #(
  parameter int unsigned US_CYC = sms_pkg::CLK_HZ / sms_pkg::US_PER_S
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              coreSupplyOk,
  input  wire logic              interfaceSupplyOk,
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic      [31:0]       regRdData,
  output sms_pkg::sms_conv_t     convReq,
  input  wire logic              convDone,
  input  wire logic [19:0]       convData,
  output logic                   pinOeN
);

  // **************************************************
  // Declarations
  // **************************************************
  logic                porDone_reg;
  logic                softRst_reg;
  logic                rstInt;
  sms_pkg::sms_state_t state_reg;
  sms_pkg::sms_state_t state_next;
  sms_pkg::sms_mode_t  mode_reg;
  sms_pkg::sms_mode_t  mode_next;
  sms_pkg::sms_mode_t  pendMode_reg;
  logic                pend_reg;
  sms_pkg::sms_meas_t  meas_reg;
  sms_pkg::sms_cfg_t   cfg_reg;
  logic [2:0]          osrsH_reg;
  logic [31:0]         sbCnt_reg;
  logic [31:0]         sbCycles;
  logic                convBusy_reg;
  sms_pkg::sms_conv_t  convReq_reg;
  logic [15:0]         humData_reg;
  logic [31:0]         regRdData_reg;
  logic                pinOeN_reg;
  sms_pkg::sms_meas_t  wrMeasVal;
  logic                wrMeas;
  logic                wrHum;
  logic                wrCfg;
  logic                wrRst;
  logic                measAccept;
  logic                humAccept;
  logic                measuring;
  logic                isForced;
  logic [2:0]          curOsr;
  logic [1:0]          curChan;
  logic                skipCur;
  logic                convHit;
  logic                stepDone;
  logic                doStart;
  logic                endPeriod;
  logic [4:0]          curRatio;
  logic [19:0]         tempOut;
  logic [19:0]         pressOut;
  logic [31:0]         rdMux;
  logic [31:0]         statusWord;

  // **************************************************
  // Reset generation
  // **************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      porDone_reg <= 1'b0;
    end else if (!coreSupplyOk) begin
      porDone_reg <= 1'b0;
    end else if (interfaceSupplyOk) begin
      porDone_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      softRst_reg <= 1'b0;
    end else begin
      softRst_reg <= wrRst && (regWrData[7:0] == sms_pkg::SOFT_RST_CODE);
    end
  end

  assign rstInt = sys_rst || !porDone_reg || softRst_reg;

  // **************************************************
  // Register decode
  // **************************************************
  assign wrMeasVal  = sms_pkg::sms_meas_t'(regWrData[7:0]);
  assign wrMeas     = regWrEn && (regAddr == sms_pkg::OFS_CTRL_MEAS);
  assign wrHum      = regWrEn && (regAddr == sms_pkg::OFS_CTRL_HUM);
  assign wrCfg      = regWrEn && (regAddr == sms_pkg::OFS_CONFIG);
  assign wrRst      = regWrEn && (regAddr == sms_pkg::OFS_RESET);
  assign measAccept = wrMeas && !pend_reg;
  assign humAccept  = wrHum && !pend_reg;
  assign measuring  = (state_reg == sms_pkg::ST_TEMP)
                   || (state_reg == sms_pkg::ST_PRESS)
                   || (state_reg == sms_pkg::ST_HUM);
  assign isForced   = (mode_reg == sms_pkg::MODE_FORCED)
                   || (mode_reg == sms_pkg::MODE_FORCED2);

  always_ff @(posedge clk) begin
    if (rstInt) begin
      meas_reg  <= sms_pkg::sms_meas_t'(sms_pkg::CTRL_MEAS_RST);
      cfg_reg   <= sms_pkg::sms_cfg_t'(sms_pkg::CONFIG_RST);
      osrsH_reg <= sms_pkg::CTRL_HUM_RST;
    end else begin
      if (measAccept) begin
        meas_reg <= wrMeasVal;
      end
      if (wrCfg) begin
        cfg_reg <= sms_pkg::sms_cfg_t'(regWrData[7:0]);
      end
      if (humAccept) begin
        osrsH_reg <= regWrData[2:0];
      end
    end
  end

  // **************************************************
  // Mode control
  // **************************************************
  assign endPeriod = (state_reg == sms_pkg::ST_HUM) && stepDone;

  always_comb begin
    mode_next = mode_reg;
    if (endPeriod) begin
      if (pend_reg) begin
        mode_next = pendMode_reg;
      end else if (measAccept) begin
        mode_next = wrMeasVal.mode;
      end else if (isForced) begin
        mode_next = sms_pkg::MODE_SLEEP;
      end
    end else if (measAccept && !measuring) begin
      mode_next = wrMeasVal.mode;
    end
  end

  always_ff @(posedge clk) begin
    if (rstInt) begin
      mode_reg     <= sms_pkg::MODE_SLEEP;
      pendMode_reg <= sms_pkg::MODE_SLEEP;
      pend_reg     <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      if (endPeriod) begin
        pend_reg <= 1'b0;
      end else if (measAccept && measuring) begin
        pendMode_reg <= wrMeasVal.mode;
        pend_reg     <= 1'b1;
      end
    end
  end

  // **************************************************
  // Measurement sequencing
  // **************************************************
  assign curOsr   = (state_reg == sms_pkg::ST_TEMP)  ? meas_reg.osrsT :
                    (state_reg == sms_pkg::ST_PRESS) ? meas_reg.osrsP :
                    osrsH_reg;
  assign curChan  = (state_reg == sms_pkg::ST_TEMP)  ? sms_pkg::CH_TEMP :
                    (state_reg == sms_pkg::ST_PRESS) ? sms_pkg::CH_PRESS :
                    sms_pkg::CH_HUM;
  assign curRatio = (curOsr > 3'h5) ? 5'h10 :
                    5'(5'h1 << (curOsr - 3'h1));
  assign skipCur  = measuring && (curOsr == 3'h0);
  assign convHit  = measuring && convBusy_reg && convDone;
  assign stepDone = skipCur || convHit;
  assign doStart  = measuring && !skipCur && !convBusy_reg;
  assign sbCycles = 32'(sms_pkg::SB_TABLE_US[cfg_reg.sbSel] * US_CYC);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sms_pkg::ST_IDLE: begin
        if (mode_reg != sms_pkg::MODE_SLEEP) begin
          state_next = sms_pkg::ST_TEMP;
        end
      end
      sms_pkg::ST_TEMP: begin
        if (stepDone) begin
          state_next = sms_pkg::ST_PRESS;
        end
      end
      sms_pkg::ST_PRESS: begin
        if (stepDone) begin
          state_next = sms_pkg::ST_HUM;
        end
      end
      sms_pkg::ST_HUM: begin
        if (stepDone) begin
          state_next = (mode_next == sms_pkg::MODE_NORMAL) ?
                       sms_pkg::ST_STANDBY : sms_pkg::ST_IDLE;
        end
      end
      sms_pkg::ST_STANDBY: begin
        if (mode_reg != sms_pkg::MODE_NORMAL) begin
          state_next = sms_pkg::ST_IDLE;
        end else if (sbCnt_reg == 32'h0) begin
          state_next = sms_pkg::ST_TEMP;
        end
      end
      default: begin
        state_next = sms_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rstInt) begin
      state_reg <= sms_pkg::ST_IDLE;
      sbCnt_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      if (endPeriod) begin
        sbCnt_reg <= sbCycles - 32'h1;
      end else if (sbCnt_reg != 32'h0) begin
        sbCnt_reg <= sbCnt_reg - 32'h1;
      end
    end
  end

  // **************************************************
  // Converter handshake and results
  // **************************************************
  always_ff @(posedge clk) begin
    if (rstInt) begin
      convBusy_reg <= 1'b0;
      convReq_reg  <= '0;
      humData_reg  <= sms_pkg::HUM_RST;
    end else begin
      convReq_reg.start <= doStart;
      if (doStart) begin
        convReq_reg.chan  <= curChan;
        convReq_reg.ratio <= curRatio;
        convBusy_reg      <= 1'b1;
      end else if (convHit) begin
        convBusy_reg <= 1'b0;
      end
      if (convHit && (state_reg == sms_pkg::ST_HUM)) begin
        humData_reg <= convData[15:0];
      end
    end
  end

  sms_iir_chan #(.W(20), .KW(3)) tempChan (
    .clk     (clk),
    .rst     (rstInt),
    .init    (wrCfg),
    .coefExp (cfg_reg.filt),
    .load    (stepDone && (state_reg == sms_pkg::ST_TEMP)),
    .skip    (skipCur),
    .adcIn   (convData),
    .dataOut (tempOut)
  );

  sms_iir_chan #(.W(20), .KW(3)) pressChan (
    .clk     (clk),
    .rst     (rstInt),
    .init    (wrCfg),
    .coefExp (cfg_reg.filt),
    .load    (stepDone && (state_reg == sms_pkg::ST_PRESS)),
    .skip    (skipCur),
    .adcIn   (convData),
    .dataOut (pressOut)
  );

  // **************************************************
  // Read path and pins
  // **************************************************
  assign statusWord = {30'h0, pend_reg, measuring};
  assign rdMux =
    (regAddr == sms_pkg::OFS_ID)        ? {24'h0, sms_pkg::CHIP_ID} :
    (regAddr == sms_pkg::OFS_CTRL_HUM)  ? {29'h0, osrsH_reg} :
    (regAddr == sms_pkg::OFS_STATUS)    ? statusWord :
    (regAddr == sms_pkg::OFS_CTRL_MEAS) ? {24'h0, meas_reg.osrsT,
                                            meas_reg.osrsP, mode_reg} :
    (regAddr == sms_pkg::OFS_CONFIG)    ? {24'h0, cfg_reg} :
    (regAddr == sms_pkg::OFS_PRESS)     ? {12'h0, pressOut} :
    (regAddr == sms_pkg::OFS_TEMP)      ? {12'h0, tempOut} :
    (regAddr == sms_pkg::OFS_HUM)       ? {16'h0, humData_reg} :
    32'h0;

  always_ff @(posedge clk) begin
    if (rstInt) begin
      regRdData_reg <= 32'h0;
    end else begin
      regRdData_reg <= regRdEn ? rdMux : 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinOeN_reg <= 1'b1;
    end else begin
      pinOeN_reg <= !(coreSupplyOk && porDone_reg && regRdEn);
    end
  end

  assign regRdData = regRdData_reg;
  assign convReq   = convReq_reg;
  assign pinOeN    = pinOeN_reg;

  // **************************************************
  // Assertions
  // **************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rstInt);

  mode_imm_a: assert property (
    (measAccept && !measuring) |=> (mode_reg == $past(wrMeasVal.mode)))
    else $error("idle mode write not applied");
  mode_defer_a: assert property (
    (measAccept && measuring && !endPeriod) |=> ($stable(mode_reg) && pend_reg))
    else $error("mode write during measurement not deferred");
  pend_block_a: assert property (
    (pend_reg && wrHum) |=> $stable(osrsH_reg))
    else $error("humidity write taken while change pending");
  forced_end_a: assert property (
    (endPeriod && isForced && !pend_reg && !measAccept) |=>
    (mode_reg == sms_pkg::MODE_SLEEP) && (state_reg == sms_pkg::ST_IDLE))
    else $error("forced mode did not return to sleep");
  conv_order_a: assert property (
    (stepDone && (state_reg == sms_pkg::ST_TEMP)) |=>
    (state_reg == sms_pkg::ST_PRESS))
    else $error("conversion order broken");
  press_hum_a: assert property (
    (stepDone && (state_reg == sms_pkg::ST_PRESS)) |=>
    (state_reg == sms_pkg::ST_HUM))
    else $error("humidity does not follow pressure");
  sb_load_a: assert property (
    (endPeriod && (mode_next == sms_pkg::MODE_NORMAL)) |=>
    (state_reg == sms_pkg::ST_STANDBY) && (sbCnt_reg == $past(sbCycles) - 1))
    else $error("standby count wrong");
  loop_a: assert property (
    ((state_reg == sms_pkg::ST_STANDBY) && (sbCnt_reg == 32'h0)
     && (mode_reg == sms_pkg::MODE_NORMAL)) |=> (state_reg == sms_pkg::ST_TEMP))
    else $error("normal mode did not restart");
  skip_mark_a: assert property (
    (skipCur && (state_reg == sms_pkg::ST_TEMP)) |=>
    (tempOut == sms_pkg::SKIP_VAL))
    else $error("skipped temperature lacks marker");
  hum_data_a: assert property (
    (convHit && (state_reg == sms_pkg::ST_HUM)) |=>
    (humData_reg == $past(convData[15:0])))
    else $error("humidity result not captured");
  hiz_pins_a: assert property (@(posedge clk) disable iff (sys_rst)
    !coreSupplyOk |=> pinOeN_reg)
    else $error("pins driven without core supply");
  sleep_boot_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(rstInt) |-> (state_reg == sms_pkg::ST_IDLE)
                      && (mode_reg == sms_pkg::MODE_SLEEP))
    else $error("not asleep after reset");

  forced_cov: cover property (endPeriod && isForced);
  normal_cov: cover property ((state_reg == sms_pkg::ST_STANDBY)
                              ##1 (state_reg == sms_pkg::ST_TEMP));
  pend_cov:   cover property (pend_reg && wrMeas);
  skip_cov:   cover property (skipCur);
endmodule

// [pkg/sms_pkg.sv]
package sms_pkg;

  // **************************************************
  // Clock and timing
  // **************************************************
  localparam int unsigned CLK_HZ   = 25000000;
  localparam int unsigned US_PER_S = 1000000;
  // Standby durations in microseconds, index is the standby select field
  localparam int unsigned SB_TABLE_US [8] = '{
    500, 62500, 125000, 250000, 500000, 1000000, 10000, 20000
  };

  // **************************************************
  // Register offsets
  // **************************************************
  localparam logic [7:0] OFS_ID        = 8'h00;
  localparam logic [7:0] OFS_CTRL_HUM  = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_CTRL_MEAS = 8'h0c;
  localparam logic [7:0] OFS_CONFIG    = 8'h10;
  localparam logic [7:0] OFS_RESET     = 8'h14;
  localparam logic [7:0] OFS_PRESS     = 8'h18;
  localparam logic [7:0] OFS_TEMP      = 8'h1c;
  localparam logic [7:0] OFS_HUM       = 8'h20;

  // **************************************************
  // Values and reset values
  // **************************************************
  localparam logic [7:0]  CHIP_ID       = 8'h3c; // Arbitrary value
  localparam logic [7:0]  SOFT_RST_CODE = 8'h5a;
  localparam logic [19:0] SKIP_VAL      = 20'h80000;
  localparam logic [19:0] DATA_RST      = 20'h00000;
  localparam logic [15:0] HUM_RST       = 16'h0000;
  localparam logic [7:0]  CTRL_MEAS_RST = 8'h00;
  localparam logic [7:0]  CONFIG_RST    = 8'h00;
  localparam logic [2:0]  CTRL_HUM_RST  = 3'h0;
  localparam int unsigned STAT_MEAS_BIT = 0;
  localparam int unsigned STAT_PEND_BIT = 1;
  localparam logic [1:0]  CH_TEMP       = 2'h0;
  localparam logic [1:0]  CH_PRESS      = 2'h1;
  localparam logic [1:0]  CH_HUM        = 2'h2;

  // **************************************************
  // Types
  // **************************************************
  typedef enum logic [1:0] {
    MODE_SLEEP   = 2'b00,
    MODE_FORCED  = 2'b01,
    MODE_FORCED2 = 2'b10,
    MODE_NORMAL  = 2'b11
  } sms_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_TEMP    = 3'b001,
    ST_PRESS   = 3'b010,
    ST_HUM     = 3'b011,
    ST_STANDBY = 3'b100
  } sms_state_t;

  typedef struct packed {
    logic [2:0] osrsT;
    logic [2:0] osrsP;
    sms_mode_t  mode;
  } sms_meas_t;

  typedef struct packed {
    logic [2:0] sbSel;
    logic [1:0] rsvd;
    logic [2:0] filt;
  } sms_cfg_t;

  typedef struct packed {
    logic       start;
    logic [1:0] chan;
    logic [4:0] ratio;
  } sms_conv_t;

endpackage

// [core/sms_iir_chan.sv]
`timescale 1ns/1ps
module sms_iir_chan #(
  parameter int W  = 20,
  parameter int KW = 3
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          init,
  input  wire logic [KW-1:0] coefExp,
  input  wire logic          load,
  input  wire logic          skip,
  input  wire logic [W-1:0]  adcIn,
  output logic      [W-1:0]  dataOut
);
  localparam int AW = W + 8;

  logic [W-1:0]  mem_reg;
  logic          primed_reg;
  logic [W-1:0]  dataOut_reg;
  logic [AW-1:0] memWide;
  logic [AW-1:0] acc;
  logic [W-1:0]  filtVal;
  logic          useRaw;
  logic [W-1:0]  newVal;

  // ************************************
  // Filter arithmetic, coefficient 2^k
  // ************************************
  assign memWide = {{(AW-W){1'b0}}, mem_reg};
  assign acc     = (memWide << coefExp) - memWide
                 + {{(AW-W){1'b0}}, adcIn};
  assign filtVal = W'(acc >> coefExp);
  assign useRaw  = !primed_reg || init || (coefExp == '0);
  assign newVal  = useRaw ? adcIn : filtVal;
  assign dataOut = dataOut_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_reg     <= sms_pkg::DATA_RST;
      primed_reg  <= 1'b0;
      dataOut_reg <= sms_pkg::DATA_RST;
    end else if (load && skip) begin
      dataOut_reg <= sms_pkg::SKIP_VAL;
      primed_reg  <= primed_reg && !init;
    end else if (load) begin
      mem_reg     <= newVal;
      dataOut_reg <= newVal;
      primed_reg  <= 1'b1;
    end else if (init) begin
      primed_reg  <= 1'b0;
    end
  end
endmodule

// [dv/sms_conv_model.sv]
`timescale 1ns/1ps
module sms_conv_model (
  input  wire logic          clk,
  input  wire logic          rst,
  input  sms_pkg::sms_conv_t convReq,
  input  wire logic [7:0]    lat,
  input  wire logic [19:0]   dataT,
  input  wire logic [19:0]   dataP,
  input  wire logic [19:0]   dataH,
  output logic               convDone,
  output logic      [19:0]   convData
);
  // ****************************************
  // Converter, answers lat cycles after start
  // ****************************************
  logic        busy;
  logic [7:0]  cnt;
  logic [1:0]  chan;
  logic [19:0] junk;
  logic [19:0] res;

  assign res = (chan == sms_pkg::CH_TEMP)  ? dataT :
               (chan == sms_pkg::CH_PRESS) ? dataP : dataH;
  // Moving pattern outside the done cycle
  assign convData = convDone ? res : junk;

  always @(posedge clk) begin
    junk     <= {junk[18:0], ~junk[19]};
    convDone <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
      junk <= 20'h0;
    end else if (convReq.start) begin
      busy <= 1'b1;
      cnt  <= lat;
      chan <= convReq.chan;
    end else if (busy && cnt <= 8'h1) begin
      busy     <= 1'b0;
      convDone <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 8'h1;
    end
  end
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // Bench state
  // ****************************************
  logic               clk, sys_rst, coreOk, ioOk, wrEn, rdEn, oeN, done;
  logic               oeSeen;
  logic [7:0]         addr, lat;
  logic [31:0]        wrData, rdData, rv;
  logic [19:0]        dT, dP, dH, cData;
  sms_pkg::sms_conv_t req;
  logic [6:0]         starts[$];
  int                 tStart[$];
  int                 cyc = 0;
  int                 failures = 0;
  int                 n_compared = 0;
  int                 per0;

  sms_sequencer #(.US_CYC(1)) u_sms_sequencer (
    .clk(clk), .sys_rst(sys_rst), .coreSupplyOk(coreOk),
    .interfaceSupplyOk(ioOk), .regAddr(addr), .regWrData(wrData),
    .regWrEn(wrEn), .regRdEn(rdEn), .regRdData(rdData), .convReq(req),
    .convDone(done), .convData(cData), .pinOeN(oeN));
  sms_conv_model u_sms_conv_model (
    .clk(clk), .rst(sys_rst), .convReq(req), .lat(lat), .dataT(dT),
    .dataP(dP), .dataH(dH), .convDone(done), .convData(cData));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Start monitor and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (req.start === 1'b1) begin
      starts.push_back({req.chan, req.ratio});
      if (req.chan === sms_pkg::CH_TEMP) tStart.push_back(cyc);
    end
    if (cyc == 60000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wrEn   <= 1'b1;
    addr   <= a;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    rv = rdData;
    oeSeen = oeN;
  endtask

  task automatic idle(input logic [31:0] m);
    for (int i = 0; i < 3000; i++) begin
      rd(sms_pkg::OFS_STATUS);
      if ((rv & m) === 32'h0) return;
    end
    chk(rv & m, 32'h0);
  endtask

  task automatic forced(input logic [7:0] m);
    starts.delete();
    wr(sms_pkg::OFS_CTRL_MEAS, {24'h0, m});
    repeat (6) @(posedge clk);
    chk(32'(starts.size() > 0), 32'h1);
    idle(32'h3);
  endtask

  function automatic logic [4:0] ratio(input int c);
    return (c >= 5) ? 5'h10 : 5'h1 << (c - 1);
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_sleep();
    rd(sms_pkg::OFS_STATUS);
    chk(rv, 32'h0);
    chk({31'h0, oeSeen}, 32'h0);
    rd(sms_pkg::OFS_ID);
    chk(rv, {24'h0, sms_pkg::CHIP_ID});
    wr(sms_pkg::OFS_CONFIG, 32'hc0);
    rd(sms_pkg::OFS_CONFIG);
    chk(rv, 32'hc0);
    wr(sms_pkg::OFS_CONFIG, 32'h0);
    repeat (50) @(posedge clk);
    chk(starts.size(), 32'h0);
    $display("test sleep done");
  endtask

  task automatic t_forced();
    logic [7:0] m;
    dT = 20'h12344;
    dP = 20'h23456;
    dH = 20'hf4320;
    wr(sms_pkg::OFS_CTRL_HUM, 32'h1);
    for (int k = 1; k < 3; k++) begin
      m = {6'h09, k[1:0]};
      forced(m);
      chk(starts.size(), 32'h3);
      chk({11'h0, starts[0], starts[1], starts[2]},
          {11'h0, 7'h01, 7'h21, 7'h41});
      rd(sms_pkg::OFS_TEMP);
      chk(rv, 32'h12344);
      rd(sms_pkg::OFS_PRESS);
      chk(rv, 32'h23456);
      rd(sms_pkg::OFS_HUM);
      chk(rv, 32'h4320);
      rd(sms_pkg::OFS_CTRL_MEAS);
      chk(rv, {24'h0, m[7:2], 2'b00});
      repeat (30) @(posedge clk);
      chk(starts.size(), 32'h3);
    end
    $display("test forced done");
  endtask

  task automatic t_osr_h();
    for (int c = 0; c < 8; c++) begin
      dH = 20'hf4300 + c;
      wr(sms_pkg::OFS_CTRL_HUM, c);
      forced(8'h25);
      rd(sms_pkg::OFS_HUM);
      if (c == 0) begin
        chk(starts.size(), 32'h2);
        chk(rv, 32'h4320);
      end else begin
        chk({25'h0, starts[2]}, {25'h0, 2'h2, ratio(c)});
        chk(rv, 32'h4300 + c);
      end
    end
    $display("test humidity oversampling done");
  endtask

  task automatic t_filter();
    wr(sms_pkg::OFS_CONFIG, 32'h1);
    dT = 20'h10000;
    dP = 20'h20000;
    forced(8'h25);
    rd(sms_pkg::OFS_TEMP);
    chk(rv, 32'h10000);
    dT = 20'h10010;
    dP = 20'h20020;
    dH = 20'h01100;
    forced(8'h25);
    rd(sms_pkg::OFS_TEMP);
    chk(rv, 32'h10008);
    rd(sms_pkg::OFS_PRESS);
    chk(rv, 32'h20010);
    rd(sms_pkg::OFS_HUM);
    chk(rv, 32'h1100);
    dT = 20'h10018;
    forced(8'h05);
    chk({30'h0, starts[0][6:5]}, {30'h0, sms_pkg::CH_PRESS});
    rd(sms_pkg::OFS_TEMP);
    chk(rv, {12'h0, sms_pkg::SKIP_VAL});
    forced(8'h25);
    rd(sms_pkg::OFS_TEMP);
    chk(rv, 32'h10010);
    wr(sms_pkg::OFS_CONFIG, 32'h0);
    $display("test filter and skip done");
  endtask

  task automatic t_defer();
    lat = 8'd60;
    wr(sms_pkg::OFS_CTRL_HUM, 32'h1);
    wr(sms_pkg::OFS_CTRL_MEAS, 32'h25);
    repeat (5) @(posedge clk);
    wr(sms_pkg::OFS_CTRL_MEAS, 32'h27);
    rd(sms_pkg::OFS_CTRL_MEAS);
    chk(rv, 32'h25);
    rd(sms_pkg::OFS_STATUS);
    chk(rv, 32'h3);
    wr(sms_pkg::OFS_CTRL_HUM, 32'h4);
    wr(sms_pkg::OFS_CTRL_MEAS, 32'h24);
    rd(sms_pkg::OFS_CTRL_HUM);
    chk(rv, 32'h1);
    idle(32'h2);
    rd(sms_pkg::OFS_CTRL_MEAS);
    chk(rv, 32'h27);
    wr(sms_pkg::OFS_CTRL_MEAS, 32'h24);
    idle(32'h3);
    rd(sms_pkg::OFS_CTRL_MEAS);
    chk(rv, 32'h24);
    lat = 8'h3;
    $display("test deferred mode change done");
  endtask

  task automatic t_normal();
    int per;
    for (int s = 0; s < 2; s++) begin
      wr(sms_pkg::OFS_CONFIG, (s == 1) ? 32'hc0 : 32'h0);
      tStart.delete();
      dT = 20'h30000;
      wr(sms_pkg::OFS_CTRL_MEAS, 32'h27);
      for (int i = 0; i < 25000 && tStart.size() < 1; i++) @(posedge clk);
      repeat (20) @(posedge clk);
      dT = 20'h3000c;
      for (int i = 0; i < 25000 && tStart.size() < 3; i++) @(posedge clk);
      rd(sms_pkg::OFS_TEMP);
      chk(rv, 32'h3000c);
      chk(tStart.size(), 32'h3);
      per = tStart[2] - tStart[1];
      if (s == 0) per0 = per;
      wr(sms_pkg::OFS_CTRL_MEAS, 32'h24);
      idle(32'h3);
    end
    chk(per - per0, 32'd9500);
    wr(sms_pkg::OFS_CONFIG, 32'h0);
    $display("test normal cycling done");
  endtask

  task automatic t_resets();
    wr(sms_pkg::OFS_CTRL_HUM, 32'h5);
    wr(sms_pkg::OFS_RESET, {24'h0, sms_pkg::SOFT_RST_CODE});
    repeat (3) @(posedge clk);
    rd(sms_pkg::OFS_CTRL_HUM);
    chk(rv, 32'h0);
    wr(sms_pkg::OFS_CTRL_HUM, 32'h6);
    ioOk <= 1'b0;
    repeat (5) @(posedge clk);
    ioOk <= 1'b1;
    rd(sms_pkg::OFS_CTRL_HUM);
    chk(rv, 32'h6);
    coreOk <= 1'b0;
    rd(sms_pkg::OFS_STATUS);
    chk({31'h0, oeSeen}, 32'h1);
    @(posedge clk);
    coreOk <= 1'b1;
    repeat (2) @(posedge clk);
    rd(sms_pkg::OFS_CTRL_HUM);
    chk(rv, 32'h0);
    rd(sms_pkg::OFS_CTRL_MEAS);
    chk(rv, 32'h0);
    $display("test resets done");
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    coreOk = 1'b1;
    ioOk = 1'b1;
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 8'h0;
    wrData = 32'h0;
    lat = 8'h3;
    dT = 20'h0;
    dP = 20'h0;
    dH = 20'h0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_sleep();
    t_forced();
    t_osr_h();
    t_filter();
    t_defer();
    t_normal();
    t_resets();
    tally_and_finish();
  end
endmodule
